// ===== rtl/cmd_timer.v
// Run timer standing in for the flash array during one command.
// Assumes start is only raised while busy_r is low.
`timescale 1ns/100ps
`default_nettype none
`include "flash_cmd_regs.vh"

module cmd_timer #(
    parameter CYC = `BUSY_CYCLES,
    parameter CW  = 16
) (
    // Clock and reset
    input  wire clk,
    input  wire rst_n,
    // Control
    input  wire start,
    input  wire abort,
    // State
    output reg  busy_r,
    output reg  done_r
);
    localparam [CW-1:0] LAST = CYC - 1;

    reg [CW-1:0] cnt_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r  <= {CW{1'b0}};
        end else begin
            done_r <= 1'b0;
            if (busy_r) begin
                // An abort ends the run early but still reports done
                if (abort || cnt_r == LAST) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end else if (start) begin
                busy_r <= 1'b1;
                cnt_r  <= {CW{1'b0}};
            end
        end
    end
endmodule

`default_nettype wire

// ===== rtl/flash_cmd_status.v
// Command buffer, status flags and interrupt requests of a flash controller.
// Assumes an APB master on pclk; mode and stop pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "flash_cmd_regs.vh"

module flash_cmd_status #(
    parameter AW       = 23,
    parameter BUSY_CYC = `BUSY_CYCLES
) (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Asynchronous pins
    input  wire        special_mode,
    input  wire        stop_req,
    input  wire        array_erased,
    // Interrupt requests
    output reg         cbe_irq,
    output reg         cc_irq,
    output reg         irq
);
    localparam SQ_IDLE = 3'b001;
    localparam SQ_WORD = 3'b010;
    localparam SQ_CMD  = 3'b100;

    // Pin synchronisers
    reg [2:0] sync1_r;
    reg [2:0] sync2_r;
    reg       stop_d_r;

    // Flags and registers
    reg        buffer_empty_flag_r;
    reg        command_done_flag_r;
    reg        protection_violation_flag_r;
    reg        sequence_error_flag_r;
    reg        blank_r;
    reg        fail_r;
    reg [7:0]  cfg_r;
    reg [AW-1:0] addr_r;
    reg [31:0] data_r;
    reg [7:0]  cmd_r;
    reg [31:0] prot_r;
    reg [2:0]  isr_r;
    reg [2:0]  imr_r;
    reg [2:0]  seq_r;
    reg        pend_v_r;
    reg [7:0]  pend_cmd_r;
    reg [7:0]  act_cmd_r;

    wire       eng_busy;
    wire       eng_done;

    wire       spec_s  = sync2_r[0];
    wire       stop_s  = sync2_r[1];
    wire       ers_s   = sync2_r[2];

    // Bus decode; writes and read side effects land in the access cycle
    wire       wr      = psel & penable & pwrite & pready;
    wire       rd      = psel & penable & ~pwrite & pready;
    wire       stat_wr = wr & (paddr == `OFF_STAT);
    wire       word_wr = wr & (paddr == `OFF_DATA);
    wire       cmd_wr  = wr & (paddr == `OFF_CMD);
    wire       isr_rd  = rd & (paddr == `OFF_ISR);
    wire       w_cbe1  = stat_wr & pwdata[`BIT_CBE];
    wire       w_cbe0  = stat_wr & ~pwdata[`BIT_CBE];

    wire       blocked = protection_violation_flag_r | sequence_error_flag_r;
    wire       open_ok = ~blocked & buffer_empty_flag_r;
    wire [7:0] wcmd    = pwdata[7:0];

    reg        wcmd_legal;
    reg        wcmd_pe;
    always @* begin
        wcmd_legal = 1'b0;
        wcmd_pe    = 1'b0;
        case (wcmd)
            `CMD_VERIFY,
            `CMD_COMPRESS,
            `CMD_ABORT:    wcmd_legal = 1'b1;
            `CMD_PROGRAM,
            `CMD_SECT_ERS,
            `CMD_MASS_ERS: begin
                wcmd_legal = 1'b1;
                wcmd_pe    = 1'b1;
            end
            default:       wcmd_legal = 1'b0;
        endcase
    end

    wire prot_hit  = ({{(32-AW){1'b0}}, addr_r} >= prot_r);
    wire pv_set    = open_ok & cmd_wr & (seq_r == SQ_WORD)
                     & wcmd_legal & wcmd_pe & prot_hit;
    wire order_err = open_ok & (
                       (w_cbe0 & (seq_r != SQ_IDLE))
                     | (w_cbe1 & (seq_r == SQ_WORD))
                     | (word_wr & (seq_r != SQ_IDLE))
                     | (cmd_wr & (seq_r != SQ_WORD))
                     | (cmd_wr & (seq_r == SQ_WORD) & ~wcmd_legal));
    wire launch    = open_ok & w_cbe1 & (seq_r == SQ_CMD);
    wire abort_cmd = launch & (cmd_r == `CMD_ABORT);
    wire cut_erase = abort_cmd & eng_busy & (act_cmd_r == `CMD_SECT_ERS);
    wire stop_hit  = stop_s & ~stop_d_r & eng_busy;
    wire eng_abort = cut_erase | stop_hit;
    wire ae_set    = order_err | eng_abort;
    wire act_vd    = (act_cmd_r == `CMD_VERIFY) | (act_cmd_r == `CMD_COMPRESS);
    wire drop      = pend_v_r & sequence_error_flag_r & act_vd & eng_done;
    wire fetch     = pend_v_r & ~eng_busy & ~drop & ~stop_hit;
    wire done_ev   = eng_done & ~fetch;
    wire verify_ok = eng_done & (act_cmd_r == `CMD_VERIFY) & ~sequence_error_flag_r;
    wire fail_set  = verify_ok & ~ers_s;
    wire [2:0] ev  = {fail_set, ae_set | pv_set, done_ev};
    wire [2:0] isr_nxt = (isr_r & ~(isr_rd ? prdata[2:0] : 3'h0)) | ev;

    cmd_timer #(
        .CYC (BUSY_CYC),
        .CW  (16)
    ) u_timer (
        .clk    (pclk),
        .rst_n  (presetn),
        .start  (fetch),
        .abort  (eng_abort),
        .busy_r (eng_busy),
        .done_r (eng_done)
    );

    // Only the second stage is read; the first feeds nothing else
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r  <= 3'h0;
            sync2_r  <= 3'h0;
            stop_d_r <= 1'b0;
        end else begin
            sync1_r  <= {array_erased, stop_req, special_mode};
            sync2_r  <= sync1_r;
            stop_d_r <= stop_s;
        end
    end

    // APB answer: data latched in setup, pready high in the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable & ~pready;
            pslverr <= 1'b0;
            if (psel & ~penable & ~pready) begin
                prdata <= 32'h00000000;
                case (paddr)
                    `OFF_STAT: prdata[7:0] <= {buffer_empty_flag_r, command_done_flag_r, protection_violation_flag_r, sequence_error_flag_r,
                                               1'b0, blank_r, fail_r, 1'b0};
                    `OFF_CFG:  prdata[7:0] <= cfg_r;
                    `OFF_ADDR: prdata[AW-1:0] <= addr_r;
                    `OFF_DATA: prdata <= data_r;
                    `OFF_CMD:  prdata[7:0] <= cmd_r;
                    `OFF_PROT: prdata <= prot_r;
                    `OFF_ISR:  prdata[2:0] <= isr_r;
                    `OFF_IMR:  prdata[2:0] <= imr_r;
                    default:   pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Software registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r  <= `RST_CFG;
            addr_r <= {AW{1'b0}};
            prot_r <= `RST_PROT;
            imr_r  <= `RST_IMR;
            isr_r  <= 3'h0;
        end else begin
            isr_r <= isr_nxt;
            if (wr & (paddr == `OFF_CFG))
                cfg_r <= {pwdata[`BIT_BUFFER_EMPTY_IRQ_ENABLE], pwdata[`BIT_DONE_IRQ_ENABLE], 6'h00};
            if (wr & (paddr == `OFF_ADDR))
                addr_r <= pwdata[AW-1:0];
            if (wr & (paddr == `OFF_PROT))
                prot_r <= pwdata;
            if (wr & (paddr == `OFF_IMR))
                imr_r <= pwdata[2:0];
        end
    end

    // Command write sequence and buffer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_r      <= SQ_IDLE;
            data_r     <= 32'h00000000;
            cmd_r      <= 8'h00;
            buffer_empty_flag_r    <= 1'b1;
            pend_v_r   <= 1'b0;
            pend_cmd_r <= 8'h00;
            act_cmd_r  <= 8'h00;
        end else begin
            case (seq_r)
                SQ_IDLE: begin
                    if (open_ok & word_wr) begin
                        data_r <= pwdata;
                        seq_r  <= SQ_WORD;
                    end
                end
                SQ_WORD: begin
                    if (pv_set | order_err)
                        seq_r <= SQ_IDLE;
                    else if (open_ok & cmd_wr) begin
                        cmd_r <= wcmd;
                        seq_r <= SQ_CMD;
                    end
                end
                SQ_CMD: begin
                    if (launch | order_err)
                        seq_r <= SQ_IDLE;
                end
                default: seq_r <= SQ_IDLE;
            endcase
            // An abort during a running sector erase acts at once; other commands queue
            if (launch & ~cut_erase) begin
                buffer_empty_flag_r    <= 1'b0;
                pend_v_r   <= 1'b1;
                pend_cmd_r <= cmd_r;
            end
            if (fetch) begin
                act_cmd_r <= pend_cmd_r;
                pend_v_r  <= 1'b0;
                buffer_empty_flag_r   <= 1'b1;
            end
            if (drop | stop_hit) begin
                pend_v_r <= 1'b0;
                buffer_empty_flag_r  <= 1'b1;
            end
        end
    end

    // Status flags; a hardware set beats a software clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_done_flag_r   <= 1'b1;
            protection_violation_flag_r  <= 1'b0;
            sequence_error_flag_r <= 1'b0;
            blank_r  <= 1'b0;
            fail_r   <= 1'b0;
        end else begin
            if (launch & ~cut_erase)
                command_done_flag_r <= 1'b0;
            else if (done_ev)
                command_done_flag_r <= 1'b1;
            if (pv_set)
                protection_violation_flag_r <= 1'b1;
            else if (stat_wr & pwdata[`BIT_PV])
                protection_violation_flag_r <= 1'b0;
            if (ae_set)
                sequence_error_flag_r <= 1'b1;
            else if (stat_wr & pwdata[`BIT_AE])
                sequence_error_flag_r <= 1'b0;
            if (launch & ~cut_erase)
                blank_r <= 1'b0;
            else if (verify_ok & ~pend_v_r)
                blank_r <= ers_s;
            if (fail_set)
                fail_r <= 1'b1;
            else if (stat_wr & pwdata[`BIT_FAIL] & spec_s)
                fail_r <= 1'b0;
        end
    end

    // Level requests; cbe_irq and cc_irq one cycle behind their flags, irq in step with isr_r
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cbe_irq <= 1'b0;
            cc_irq  <= 1'b0;
            irq     <= 1'b0;
        end else begin
            cbe_irq <= buffer_empty_flag_r & cfg_r[`BIT_BUFFER_EMPTY_IRQ_ENABLE];
            cc_irq  <= command_done_flag_r & cfg_r[`BIT_DONE_IRQ_ENABLE];
            irq     <= |(isr_nxt & imr_r);
        end
    end
endmodule

`default_nettype wire

// ===== shared/flash_cmd_regs.vh
// Register map, field positions, reset values and command codes
// of the flash command status block. Definitions only.
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH

// Byte offsets on the APB
`define OFF_STAT      8'h00
`define OFF_CFG       8'h04
`define OFF_ADDR      8'h08
`define OFF_DATA      8'h0C
`define OFF_CMD       8'h10
`define OFF_PROT      8'h14
`define OFF_ISR       8'h18
`define OFF_IMR       8'h1C

// Status register bits
`define BIT_CBE       7
`define BIT_CC        6
`define BIT_PV        5
`define BIT_AE        4
`define BIT_BLANK     2
`define BIT_FAIL      1

// Configuration register bits
`define BIT_BUFFER_EMPTY_IRQ_ENABLE     7
`define BIT_DONE_IRQ_ENABLE      6

// Event bits of the interrupt status and mask registers
`define EV_DONE       0
`define EV_ERR        1
`define EV_FAIL       2

// Reset values
`define RST_CFG       8'h00
`define RST_PROT      32'hFFFFFFFF
`define RST_IMR       3'h0

// Command codes
`define CMD_VERIFY    8'h05
`define CMD_COMPRESS  8'h06
`define CMD_PROGRAM   8'h20
`define CMD_SECT_ERS  8'h40
`define CMD_MASS_ERS  8'h41
`define CMD_ABORT     8'h47

// Default run time of one array command, in pclk cycles
`define BUSY_CYCLES   32

`endif

// ===== verification/apb_cpu.sv
// CPU model: APB master issuing one register transfer per toggle of go.
// Assumes requests change on pclk; hung rises if the slave stays silent 16 cycles.
`timescale 1ns/100ps
`default_nettype none
module apb_cpu (
    // Clock
    input  wire logic        pclk,
    // Request from the test sequence
    input  wire logic        go,
    input  wire logic        go_write,
    input  wire logic [7:0]  go_addr,
    input  wire logic [31:0] go_data,
    // Answer; done_tog follows go once the transfer is over
    output var  logic        done_tog,
    output var  logic [31:0] rsp_data,
    output var  logic        rsp_err,
    // APB
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Status
    output var  logic        hung
);
    int n;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hung = 1'b0;
        done_tog = 1'b0;
        rsp_data = 32'h0;
        rsp_err = 1'b0;
    end
    // Setup right after the edge that shows a new request, access until pready
    always @(posedge pclk) begin
        if (go !== done_tog) begin
            psel <= 1'b1;
            pwrite <= go_write;
            paddr <= go_addr;
            pwdata <= go_data;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (pready !== 1'b1 && n < 16);
            if (pready !== 1'b1) hung <= 1'b1;
            rsp_data <= prdata;
            rsp_err <= pslverr;
            done_tog <= go;
            psel <= 1'b0;
            penable <= 1'b0;
            // Released data lines never keep the last value
            pwdata <= ~go_data;
        end
    end
endmodule
`default_nettype wire

// ===== verification/flash_cmd_status_assertions.sv
// Concurrent checks on the APB and interrupt pins of the flash status block.
// Sees only the top module ports; bound to every instance of the block.
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_status_assertions (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and interrupts
    input wire logic        special_mode,
    input wire logic        stop_req,
    input wire logic        array_erased,
    input wire logic        cbe_irq,
    input wire logic        cc_irq,
    input wire logic        irq
);
    // Shadows of the enables, updated on the edge a write completes
    logic [1:0] cfg_sh;
    logic [2:0] imr_sh;
    wire        wr_done = psel && penable && pready && pwrite;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_sh <= 2'h0;
            imr_sh <= 3'h0;
        end else if (wr_done) begin
            if (paddr == 8'h04) cfg_sh <= pwdata[7:6];
            if (paddr == 8'h1C) imr_sh <= pwdata[2:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_setup_answer: assert property (psel && !penable |=> pready) else $error("no answer after setup");
    chk_ready_single: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    chk_unmapped_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error read not zero");
    chk_stat_rsvd: assert property (pready && !pwrite && paddr == 8'h00 |->
        prdata[31:8] == 24'h0 && prdata[3] == 1'b0 && prdata[0] == 1'b0) else $error("status spare bits set");
    chk_cfg_readback: assert property (pready && !pwrite && paddr == 8'h04 |->
        prdata == {24'h0, cfg_sh, 6'h0}) else $error("config read differs");
    // Interrupt outputs lag their causes by one cycle, hence the past value
    chk_cbe_irq_enable: assert property (cbe_irq |-> $past(cfg_sh[1])) else $error("cbe_irq while disabled");
    chk_cc_irq_enable: assert property (cc_irq |-> $past(cfg_sh[0])) else $error("cc_irq while disabled");
    chk_irq_masked: assert property (irq |-> $past(imr_sh) != 3'h0) else $error("irq with all masked");
    cover property (cbe_irq);
    cover property (cc_irq);
    cover property (irq);
    cover property (pslverr);
endmodule
bind flash_cmd_status flash_cmd_status_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .special_mode(special_mode), .stop_req(stop_req), .array_erased(array_erased),
    .cbe_irq(cbe_irq), .cc_irq(cc_irq), .irq(irq));
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the flash command status block.
// Assumes a shortened command run time of 24 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        pclk, presetn, special_mode, stop_req, array_erased, e;
    logic        go, go_write;
    logic [7:0]  go_addr;
    logic [31:0] q, go_data;
    wire         psel, penable, pwrite, pready, pslverr, cbe_irq, cc_irq, irq, hung;
    wire         done_tog, rsp_err;
    wire  [7:0]  paddr;
    wire  [31:0] pwdata, prdata, rsp_data;
    int          n_errors, checks;
    flash_cmd_status #(.AW(23), .BUSY_CYC(24)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .special_mode(special_mode), .stop_req(stop_req), .array_erased(array_erased),
        .cbe_irq(cbe_irq), .cc_irq(cc_irq), .irq(irq));
    apb_cpu cpu (.pclk(pclk), .go(go), .go_write(go_write), .go_addr(go_addr), .go_data(go_data),
        .done_tog(done_tog), .rsp_data(rsp_data), .rsp_err(rsp_err), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hung(hung));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One transfer through the CPU model; an answer that never comes ends the run
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        go_write <= w;
        go_addr <= a;
        go_data <= d;
        go <= ~go;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (done_tog !== go && n < 40);
        q = rsp_data;
        e = rsp_err;
        if (done_tog !== go) begin
            n_errors++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), exp, q);
    endtask
    // Word, command, launch; a fail clear goes first, which only takes effect in special mode
    task automatic seq(input logic [7:0] cmd);
        xfer(1'b1, 8'h00, 32'h02);
        xfer(1'b1, 8'h0C, 32'h1234);
        xfer(1'b1, 8'h10, {24'h0, cmd});
        xfer(1'b1, 8'h00, 32'h80);
    endtask
    // Polls status until bit b is set; a stuck flag ends the run
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        do begin
            xfer(1'b0, 8'h00, 32'h0);
            n++;
        end while (q[b] !== 1'b1 && n < 100);
        if (q[b] !== 1'b1) begin
            n_errors++;
            wrap_up();
        end
    endtask
    always @(posedge hung) begin
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (30000) @(posedge pclk);
        n_errors++;
        wrap_up();
    end
    initial begin
        presetn = 1'b0;
        special_mode = 1'b0;
        stop_req = 1'b0;
        array_erased = 1'b1;
        go = 1'b0;
        go_write = 1'b0;
        go_addr = 8'h00;
        go_data = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(8'h00, 32'hC0);
        rdc(8'h04, 32'h0);
        rdc(8'h14, 32'hFFFFFFFF);
        rdc(8'h1C, 32'h0);
        xfer(1'b0, 8'h20, 32'h0);
        chk("slverr", 1, e);
        chk("unmapped", 0, q);
        wr(8'h00, 32'h4F);
        rdc(8'h00, 32'hC0);
        wr(8'h04, 32'hC0);
        repeat (2) @(posedge pclk);
        chk("cbe_irq", 1, cbe_irq);
        chk("cc_irq", 1, cc_irq);
        wr(8'h04, 32'h40);
        repeat (2) @(posedge pclk);
        chk("cbe_irq", 0, cbe_irq);
        chk("cc_irq", 1, cc_irq);
        wr(8'h04, 32'h0);
        repeat (2) @(posedge pclk);
        chk("cc_irq", 0, cc_irq);
        seq(8'h05);
        wait_flag(6);
        rdc(8'h00, 32'hC4);
        array_erased <= 1'b0;
        seq(8'h05);
        wait_flag(6);
        rdc(8'h00, 32'hC2);
        wr(8'h00, 32'h02);
        rdc(8'h00, 32'hC2);
        special_mode <= 1'b1;
        array_erased <= 1'b1;
        repeat (3) @(posedge pclk);
        wr(8'h00, 32'h02);
        rdc(8'h00, 32'hC0);
        wr(8'h0C, 32'h55);
        wr(8'h00, 32'h0);
        rdc(8'h00, 32'hD0);
        seq(8'h20);
        wr(8'h00, 32'h0);
        rdc(8'h00, 32'hD0);
        wr(8'h00, 32'h10);
        seq(8'h33);
        rdc(8'h00, 32'hD0);
        wr(8'h00, 32'h10);
        wr(8'h14, 32'h100);
        wr(8'h08, 32'h200);
        seq(8'h20);
        rdc(8'h00, 32'hE0);
        wr(8'h00, 32'h20);
        wr(8'h14, 32'hFFFFFFFF);
        seq(8'h40);
        repeat (4) @(posedge pclk);
        stop_req <= 1'b1;
        wait_flag(6);
        rdc(8'h00, 32'hD0);
        stop_req <= 1'b0;
        wr(8'h00, 32'h10);
        seq(8'h40);
        seq(8'h47);
        wait_flag(6);
        rdc(8'h00, 32'hD0);
        wr(8'h00, 32'h10);
        // Stop during a compress with a program pending: the program must never run
        seq(8'h06);
        seq(8'h20);
        stop_req <= 1'b1;
        repeat (6) @(posedge pclk);
        rdc(8'h00, 32'hD0);
        stop_req <= 1'b0;
        wr(8'h00, 32'h10);
        seq(8'h20);
        seq(8'h20);
        rdc(8'h00, 32'h0);
        wait_flag(7);
        chk("done", 0, q[6]);
        wait_flag(6);
        chk("status", 32'hC0, q);
        chk("irq", 0, irq);
        wr(8'h1C, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq", 1, irq);
        rdc(8'h18, 32'h7);
        repeat (2) @(posedge pclk);
        chk("irq", 0, irq);
        rdc(8'h18, 32'h0);
        // Reset in mid-sequence: everything back to idle, a fresh sequence runs clean
        wr(8'h04, 32'hC0);
        wr(8'h0C, 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk("cbe_irq", 0, cbe_irq);
        rdc(8'h04, 32'h0);
        rdc(8'h00, 32'hC0);
        seq(8'h05);
        wait_flag(6);
        chk("status", 32'hC4, q);
        seq(8'h41);
        wait_flag(6);
        chk("status", 32'hC0, q);
        seq(8'h47);
        wait_flag(6);
        chk("status", 32'hC0, q);
        wrap_up();
    end
endmodule
`default_nettype wire
